// *** shared/sse_pkg.sv ***
package sse_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFF_FIFO_FILL = 10'h34d;
  localparam logic [9:0] OFF_SYNC_OFFSET = 10'h34e;
  localparam logic [9:0] OFF_CNT_TEST = 10'h34e;
  localparam logic [9:0] OFF_ERR_STATUS = 10'h34f;
  localparam logic [9:0] OFF_ERR_CLEAR = 10'h34f;
  localparam logic [9:0] OFF_IRQ_EN0 = 10'h350;
  localparam logic [9:0] OFF_IRQ_EN1 = 10'h351;

  // ****************************************
  // field positions
  // ****************************************
  localparam int FF_OFFSET_NZ = 5;
  localparam int FF_EMPTY = 4;
  localparam int FF_FULL = 3;
  localparam int TST_UP = 3;
  localparam int TST_DOWN = 2;
  localparam int TST_CARRY = 0;
  localparam int ERR_SYNC = 2;
  localparam int ERR_WRITE = 1;
  localparam int ERR_READ = 0;

  // ****************************************
  // masks and reset values
  // ****************************************
  localparam logic [7:0] TST_MASK = 8'h0d;
  localparam logic [2:0] ERR_RST = 3'h0;
  localparam logic [7:0] TST_RST = 8'h00;
  localparam logic [6:0] EN0_RST = 7'h00;
  localparam logic [7:0] EN1_RST = 8'h00;
  localparam logic [3:0] OUTSTANDING_OFFSET_COUNT_RST = 4'h0;
  localparam logic [23:0] XFER_RST = 24'h000000;

  // ****************************************
  // select abort counter stage limits and transfer counter stage count
  // ****************************************
  localparam logic [7:0] SA_S1_MAX = 8'hff;
  localparam logic [7:0] SA_S2_MAX = 8'hff;
  localparam logic [3:0] SA_DEC_MAX = 4'h9;
  localparam int XFER_STAGES = 3;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [2:0] fifo_byte_count;
    logic fifo_empty_flag;
    logic fifo_full_flag;
    logic req_pulse;
    logic ack_pulse;
    logic sync_start;
    logic sync_inbound;
    logic [2:0] wr_src_en;
    logic [2:0] rd_src_en;
  } sse_core_t;

  typedef struct packed {
    logic [6:0] status0;
    logic [7:0] status1;
  } sse_events_t;

  typedef struct packed {
    logic load;
    logic [23:0] load_val;
    logic byte_done;
  } sse_xfer_t;

endpackage : sse_pkg

// *** logic/sse_offset_cnt.sv ***
`timescale 1ns/100ps
module sse_offset_cnt
  import sse_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // handshake events
  input wire logic req_pulse,
  input wire logic ack_pulse,
  // count
  output logic [3:0] count
);

  logic [3:0] count_ff;
  logic [3:0] nxt_count;
  wire inc = req_pulse & ~ack_pulse & (count_ff != 4'hf);
  wire dec = ack_pulse & ~req_pulse & (count_ff != 4'h0);

  // req and ack in one cycle cancel; saturate rather than wrap
  assign nxt_count = inc ? 4'(count_ff + 4'h1) :
                     dec ? 4'(count_ff - 4'h1) : count_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_ff <= OUTSTANDING_OFFSET_COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;

endmodule : sse_offset_cnt

// *** logic/sse_sel_abort_cnt.sv ***
`timescale 1ns/100ps
module sse_sel_abort_cnt
  import sse_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic carry_test,
  // results
  output logic timeout,
  output logic [5:0] test_view
);

  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] s4_ff;
  logic s5_ff;
  logic s6_ff;

  // carry test forces every stage to see a carry in
  wire c1 = run & (s1_ff == SA_S1_MAX);
  wire c2 = c1 & (s2_ff == SA_S2_MAX);
  wire c3 = c2 & (s3_ff == SA_DEC_MAX);
  wire c4 = c3 & (s4_ff == SA_DEC_MAX);
  wire c5 = c4 & s5_ff;
  wire t2 = c1 | carry_test;
  wire t3 = c2 | carry_test;
  wire t4 = c3 | carry_test;
  wire t5 = c4 | carry_test;
  wire t6 = c5 | carry_test;
  wire t1 = run | carry_test;

  function automatic logic [3:0] dec_inc(input logic [3:0] v);
    dec_inc = (v == SA_DEC_MAX) ? 4'h0 : 4'(v + 4'h1);
  endfunction : dec_inc

  always_ff @(posedge clk) begin
    if (sys_rst | clear) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 4'h0;
      s4_ff <= 4'h0;
      s5_ff <= 1'b0;
      s6_ff <= 1'b0;
    end else begin
      if (t1) s1_ff <= 8'(s1_ff + 8'h01);
      if (t2) s2_ff <= 8'(s2_ff + 8'h01);
      if (t3) s3_ff <= dec_inc(s3_ff);
      if (t4) s4_ff <= dec_inc(s4_ff);
      if (t5) s5_ff <= ~s5_ff;
      if (t6) s6_ff <= ~s6_ff;
    end
  end

  assign timeout = c5 & s6_ff;
  // stage outputs and carries as seen by the count read-back
  assign test_view = {s6_ff, s5_ff, s4_ff[3], c3, c2, c1};

endmodule : sse_sel_abort_cnt

// *** logic/sse_regs.sv ***
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
// Operation
// - status bit 5 reads one while the req/ack offset is non-zero
// - fifo status bit 4 flags empty, bit 3 flags full
// - bits 2..0 give the fifo byte count; zero needs the flags
// - offset status bits 7..4 show fifo count minus offset count
// - offset status bits 3..0 count reqs not yet acked, reset zero
// - test bit 3 counts transfer counter up, bit 2 down, per clock
// - test bit 0 forces carries between all stages of both counters
// - carry test with select timer shows select counter stages on read-back
// - sync error sets when inbound sync transfer starts with fifo not empty
// - sync error sets when sync transfer starts with offset non-zero
// - write conflict flag sets when several sources write the fifo
// - read conflict flag sets when several sources read the fifo
// - error status bits 7..3 and fifo status bit 6 read zero
// - writing one to a clear bit clears its error flag; zero ignored
// - enable zero bits 6..0 gate status zero events onto irq; bit 7 zero
// - enable one bits 7..0 gate status one events onto irq
// - a cleared enable only masks irq; status still sets
module sse_regs
  import sse_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // scsi core status
  input wire sse_core_t core,
  input wire sse_events_t events,
  input wire logic select_timer_enable,
  input wire logic sel_timer_run,
  input wire logic sel_timer_clear,
  input wire sse_xfer_t xfer,
  // results
  output logic [7:0] xfer_count_rd,
  output logic [23:0] xfer_count,
  output logic select_timeout,
  output logic [2:0] err_flags,
  output logic irq
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic multi_src(input logic [2:0] v);
    multi_src = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : multi_src

  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] off
  );
    hit = (a == off);
  endfunction : hit

  // ****************************************
  // register state
  // ****************************************
  logic [2:0] err_ff;
  logic [2:0] nxt_err;
  logic [7:0] test_ff;
  logic [6:0] en0_ff;
  logic [7:0] en1_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [23:0] xfer_ff;
  logic [23:0] nxt_xfer;
  logic [3:0] off_cnt;
  logic sa_timeout;
  logic [5:0] sa_view;

  // ****************************************
  // address decode
  // ****************************************
  wire wr_test = reg_wr & hit(reg_addr, OFF_CNT_TEST);
  wire wr_clear = reg_wr & hit(reg_addr, OFF_ERR_CLEAR);
  wire wr_en0 = reg_wr & hit(reg_addr, OFF_IRQ_EN0);
  wire wr_en1 = reg_wr & hit(reg_addr, OFF_IRQ_EN1);
  wire rd_fill = hit(reg_addr, OFF_FIFO_FILL);
  wire rd_sync = hit(reg_addr, OFF_SYNC_OFFSET);
  wire rd_err = hit(reg_addr, OFF_ERR_STATUS);
  wire rd_en0 = hit(reg_addr, OFF_IRQ_EN0);
  wire rd_en1 = hit(reg_addr, OFF_IRQ_EN1);

  // ****************************************
  // test controls
  // ****************************************
  // test modes are only for bring-up; nothing stops a stray write
  wire test_up = test_ff[TST_UP];
  wire test_down = test_ff[TST_DOWN];
  wire carry_test = test_ff[TST_CARRY];

  // ****************************************
  // offset counter
  // ****************************************
  sse_offset_cnt u_offset (
    .clk(clk),
    .sys_rst(sys_rst),
    .req_pulse(core.req_pulse),
    .ack_pulse(core.ack_pulse),
    .count(off_cnt)
  );

  wire offset_nonzero = (off_cnt != 4'h0);
  // unsigned difference wraps; it is only meaningful when stopped
  wire [3:0] count_difference =
    4'({1'b0, core.fifo_byte_count} - off_cnt);

  // ****************************************
  // select abort counter
  // ****************************************
  sse_sel_abort_cnt u_sel_abort (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(select_timer_enable & sel_timer_run),
    .clear(sel_timer_clear),
    .carry_test(carry_test),
    .timeout(sa_timeout),
    .test_view(sa_view)
  );

  assign select_timeout = sa_timeout;

  // ****************************************
  // transfer counter
  // ****************************************
  logic [23:0] xfer_stage_inc;
  always_comb begin
    for (int i = 0; i < XFER_STAGES; i++) begin
      xfer_stage_inc[i*8 +: 8] = 8'(xfer_ff[i*8 +: 8] + 8'h01);
    end
  end

  // carry test lets every byte stage step on its own each clock
  assign nxt_xfer =
    xfer.load ? xfer.load_val :
    carry_test ? xfer_stage_inc :
    test_up ? 24'(xfer_ff + 24'h000001) :
    test_down ? 24'(xfer_ff - 24'h000001) :
    (xfer.byte_done && xfer_ff != XFER_RST) ?
      24'(xfer_ff - 24'h000001) : xfer_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xfer_ff <= XFER_RST;
    end else begin
      xfer_ff <= nxt_xfer;
    end
  end

  wire sa_readback = carry_test & select_timer_enable;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xfer_count_rd <= 8'h00;
    end else if (sa_readback) begin
      xfer_count_rd <= {2'b00, sa_view};
    end else begin
      xfer_count_rd <= nxt_xfer[7:0];
    end
  end

  assign xfer_count = xfer_ff;

  // ****************************************
  // error flags
  // ****************************************
  wire sync_err_set =
    (core.sync_start & core.sync_inbound & ~core.fifo_empty_flag)
    | (core.sync_start & offset_nonzero);
  wire [2:0] err_set;
  assign err_set[ERR_SYNC] = sync_err_set;
  assign err_set[ERR_WRITE] = multi_src(core.wr_src_en);
  assign err_set[ERR_READ] = multi_src(core.rd_src_en);
  wire [2:0] err_clr = wr_clear ? reg_wdata[2:0] : 3'h0;

  // a new event in the clearing cycle survives the clear
  assign nxt_err = (err_ff & ~err_clr) | err_set;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_ff <= ERR_RST;
    end else begin
      err_ff <= nxt_err;
    end
  end

  assign err_flags = err_ff;

  // ****************************************
  // writable registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_ff <= TST_RST;
    end else if (wr_test) begin
      test_ff <= reg_wdata & TST_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en0_ff <= EN0_RST;
    end else if (wr_en0) begin
      en0_ff <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en1_ff <= EN1_RST;
    end else if (wr_en1) begin
      en1_ff <= reg_wdata;
    end
  end

  // ****************************************
  // interrupt gating
  // ****************************************
  // enables mask only the request; status inputs stay unaffected
  wire irq0 = |(events.status0 & en0_ff);
  wire irq1 = |(events.status1 & en1_ff);
  assign irq = irq0 | irq1;

  // ****************************************
  // read path
  // ****************************************
  // reads are registered so the data stands only in the cycle after the strobe;
  // an idle cycle returns zero, which keeps stale status off the bus
  // and lets a polling host spot a missed read
  wire [7:0] fill_view = {
    1'b0,
    1'b0,
    offset_nonzero,
    core.fifo_empty_flag,
    core.fifo_full_flag,
    core.fifo_byte_count
  };
  // counts may move mid-transfer, so reads are only trusted when idle
  wire [7:0] sync_view = {count_difference, off_cnt};
  wire [7:0] err_view = {5'h00, err_ff};
  wire [7:0] en0_view = {1'b0, en0_ff};

  assign nxt_rdata =
    !reg_rd ? 8'h00 :
    rd_fill ? fill_view :
    rd_sync ? sync_view :
    rd_err ? err_view :
    rd_en0 ? en0_view :
    rd_en1 ? en1_ff : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : sse_regs

// *** sim/sse_regs_asserts.sv ***
`timescale 1ns/100ps
module sse_regs_asserts
  import sse_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // status
  input wire sse_core_t core,
  input wire sse_events_t events,
  input wire logic [2:0] err_flags,
  input wire logic irq
);
  // ****
  // shadow enables, tracked from bus writes
  // ****
  logic [6:0] en0_ff;
  logic [7:0] en1_ff;
  logic clr_wr;
  logic [2:0] keep_flags;
  assign clr_wr = reg_wr && (reg_addr == OFF_ERR_CLEAR);
  assign keep_flags = err_flags & ~(clr_wr ? reg_wdata[2:0] : 3'h0);
  always_ff @(posedge clk) begin
    if (sys_rst) en0_ff <= EN0_RST;
    else if (reg_wr && reg_addr == OFF_IRQ_EN0) en0_ff <= reg_wdata[6:0];
  end
  always_ff @(posedge clk) begin
    if (sys_rst) en1_ff <= EN1_RST;
    else if (reg_wr && reg_addr == OFF_IRQ_EN1) en1_ff <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // assertions
  // ****
  a_irq_gate: assert property (irq == ((|(events.status0 & en0_ff)) || (|(events.status1 & en1_ff))))
    else $error("irq does not match enabled events");
  a_write_conflict: assert property ($countones(core.wr_src_en) > 1 |=> err_flags[ERR_WRITE])
    else $error("write conflict flag not set");
  a_read_conflict: assert property ($countones(core.rd_src_en) > 1 |=> err_flags[ERR_READ])
    else $error("read conflict flag not set");
  a_sync_fifo: assert property (core.sync_start && core.sync_inbound && !core.fifo_empty_flag
    |=> err_flags[ERR_SYNC]) else $error("sync error flag not set");
  a_flag_hold: assert property (keep_flags != 3'h0 |=> (err_flags & $past(keep_flags)) == $past(keep_flags))
    else $error("error flag dropped without clear");
  a_clear_read: assert property (clr_wr && reg_wdata[ERR_READ] && $countones(core.rd_src_en) < 2
    |=> !err_flags[ERR_READ]) else $error("read conflict flag not cleared");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_err_read: assert property (reg_rd && reg_addr == OFF_ERR_STATUS
    |=> reg_rdata == {5'h00, $past(err_flags)}) else $error("error status read wrong");
  a_fifo_read: assert property (reg_rd && reg_addr == OFF_FIFO_FILL |=> reg_rdata[7:6] == 2'h0 &&
    reg_rdata[4:0] == $past({core.fifo_empty_flag, core.fifo_full_flag, core.fifo_byte_count}))
    else $error("fifo status read wrong");
endmodule : sse_regs_asserts

bind sse_regs sse_regs_asserts i_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core(core), .events(events), .err_flags(err_flags), .irq(irq));

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
  import sse_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  // fifo empty flag high, all else idle
  sse_core_t core = 15'h0800;
  sse_events_t events = 15'h0000;
  sse_xfer_t xfer = 26'h0000000;
  logic sel_en = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] xfer_count_rd;
  logic [23:0] xfer_count;
  logic select_timeout;
  logic [2:0] err_flags;
  logic irq;
  int err_count = 0;
  int compares = 0;
  always #5 clk = ~clk;
  sse_regs i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core(core), .events(events),
    .select_timer_enable(sel_en), .sel_timer_run(1'b0), .sel_timer_clear(1'b0), .xfer(xfer),
    .xfer_count_rd(xfer_count_rd), .xfer_count(xfer_count), .select_timeout(select_timeout),
    .err_flags(err_flags), .irq(irq));
  // ****
  // shared tasks
  // ****
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string name, input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(name, {16'h0000, exp}, {16'h0000, reg_rdata});
  endtask : rd_chk
  task automatic hs(input int n_req, input int n_ack);
    repeat (n_req) begin
      @(posedge clk);
      core.req_pulse <= 1'b1;
      @(posedge clk);
      core.req_pulse <= 1'b0;
    end
    repeat (n_ack) begin
      @(posedge clk);
      core.ack_pulse <= 1'b1;
      @(posedge clk);
      core.ack_pulse <= 1'b0;
    end
  endtask : hs
  task automatic src_pulse(input logic [2:0] w, input logic [2:0] r, input logic s);
    @(posedge clk);
    core.wr_src_en <= w;
    core.rd_src_en <= r;
    core.sync_start <= s;
    @(posedge clk);
    core.wr_src_en <= 3'h0;
    core.rd_src_en <= 3'h0;
    core.sync_start <= 1'b0;
    tick(3);
  endtask : src_pulse
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rd_chk("fill", OFF_FIFO_FILL, 8'h10);
    rd_chk("offset", OFF_SYNC_OFFSET, 8'h00);
    rd_chk("err", OFF_ERR_STATUS, 8'h00);
    rd_chk("en0", OFF_IRQ_EN0, 8'h00);
    rd_chk("en1", OFF_IRQ_EN1, 8'h00);
    rd_chk("unmapped", 10'h000, 8'h00);
    chk("irq", 24'h000000, {23'h000000, irq});
  endtask : t_reset
  task automatic t_fifo;
    @(posedge clk);
    core.fifo_byte_count <= 3'h0;
    core.fifo_empty_flag <= 1'b0;
    core.fifo_full_flag <= 1'b1;
    rd_chk("full", OFF_FIFO_FILL, 8'h08);
    @(posedge clk);
    core.fifo_byte_count <= 3'h5;
    core.fifo_full_flag <= 1'b0;
    rd_chk("count", OFF_FIFO_FILL, 8'h05);
  endtask : t_fifo
  task automatic t_offset;
    hs(3, 1);
    // offset status is read only with the handshake stopped
    rd_chk("diff", OFF_SYNC_OFFSET, 8'h32);
    rd_chk("nonzero", OFF_FIFO_FILL, 8'h25);
    src_pulse(3'h0, 3'h0, 1'b1);
    chk("sync_off", 24'h000004, {21'h000000, err_flags});
    hs(0, 2);
    rd_chk("drained", OFF_SYNC_OFFSET, 8'h50);
    rd_chk("zero", OFF_FIFO_FILL, 8'h05);
    wr(OFF_ERR_CLEAR, 8'h04);
    tick(1);
    chk("clr_sync", 24'h000000, {21'h000000, err_flags});
  endtask : t_offset
  task automatic t_errors;
    src_pulse(3'h3, 3'h0, 1'b0);
    chk("wr_conf", 24'h000002, {21'h000000, err_flags});
    src_pulse(3'h0, 3'h5, 1'b0);
    chk("rd_conf", 24'h000003, {21'h000000, err_flags});
    core.sync_inbound <= 1'b1;
    src_pulse(3'h0, 3'h0, 1'b1);
    core.sync_inbound <= 1'b0;
    rd_chk("all_err", OFF_ERR_STATUS, 8'h07);
    wr(OFF_ERR_CLEAR, 8'h02);
    wr(OFF_ERR_CLEAR, 8'h00);
    tick(1);
    chk("clr_one", 24'h000005, {21'h000000, err_flags});
    wr(OFF_ERR_CLEAR, 8'hfd);
    tick(1);
    chk("clr_all", 24'h000000, {21'h000000, err_flags});
  endtask : t_errors
  task automatic t_irq;
    wr(OFF_IRQ_EN0, 8'hff);
    rd_chk("en0_rb", OFF_IRQ_EN0, 8'h7f);
    wr(OFF_IRQ_EN1, 8'hff);
    rd_chk("en1_rb", OFF_IRQ_EN1, 8'hff);
    for (int i = 0; i < 15; i++) begin
      events <= 15'h0001 << i;
      tick(1);
      chk("irq_on", 24'h000001, {23'h000000, irq});
    end
    wr(OFF_IRQ_EN0, 8'h00);
    wr(OFF_IRQ_EN1, 8'h00);
    events <= 15'h7fff;
    tick(1);
    chk("masked", 24'h000000, {23'h000000, irq});
    events <= 15'h0000;
  endtask : t_irq
  task automatic t_count;
    logic [23:0] a;
    // test register is touched only here, outside normal traffic
    wr(OFF_CNT_TEST, 8'h08);
    tick(1);
    a = xfer_count;
    tick(10);
    chk("up", 24'h00000a, xfer_count - a);
    wr(OFF_CNT_TEST, 8'h04);
    tick(1);
    a = xfer_count;
    tick(10);
    chk("down", 24'h00000a, a - xfer_count);
    wr(OFF_CNT_TEST, 8'h00);
    @(posedge clk);
    xfer.load <= 1'b1;
    xfer.load_val <= 24'h101010;
    @(posedge clk);
    xfer.load <= 1'b0;
    sel_en <= 1'b1;
    // byte stages start low so no stage wraps inside the window
    wr(OFF_CNT_TEST, 8'h01);
    tick(1);
    a = xfer_count;
    tick(10);
    chk("carry", 24'h0a0a0a, xfer_count - a);
    chk("view", 24'h000000, {22'h000000, xfer_count_rd[7:6]});
    wr(OFF_CNT_TEST, 8'h00);
    sel_en <= 1'b0;
  endtask : t_count
  // ****
  // run control
  // ****
  task automatic report_and_stop;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_fifo;
    t_offset;
    t_errors;
    t_irq;
    t_count;
    report_and_stop;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    err_count++;
    report_and_stop;
  end
endmodule : tb
